// ==== sps_pkg.sv ====
// Package of constants and types for the supply protection sequencer
// What this block does
// [RL1] Soft start rail and feedback high: odd-skip restart
// [RL2] Rail above top level: odd-skip restart always
// [RL3] Over temperature: odd-skip non-switching restart
// [RL4] Temperature release only at lower comparator
// [RL5] Rail low: shut down, recharge, turn on
// [RL6] Overload starts built-in timer, then extended counter
// [RL7] Extended step: discharge low, charge high, count
// [RL8] Count of 256 stops counter, done high
// [RL9] Done and overload after spike filter: odd-skip
// [RL10] Blanking is built-in plus extended interval
// [RL11] Brownout active from rail low level before turn-on
// [RL12] Brownout mode active by default at start-up
// [RL13] Brownout suppresses switching, keeps sensing input
// [RL14] Pin above reference clears latch, load off
// [RL15] Pin below reference sets latch, load on
// [RL16] Odd-skip: odd cycles skip detection and switching
// [RL17] Non-switching odd-skip: even cycles also no pulses
// [RL18] Inputs synchronised, timing counted on clock
package sps_pkg;
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned BLANK_MS = 20;
   localparam int unsigned BLANK_CYC = BLANK_MS * (CLK_HZ / 1000);
   localparam int unsigned SPIKE_US = 30;
   localparam int unsigned SPIKE_CYC = SPIKE_US * (CLK_HZ / 1000000);
   localparam int unsigned EXT_COUNT = 256;
   localparam int unsigned SYNC_W = 10;
   typedef enum logic [1:0] {
      SPS_MODE_NORMAL,
      SPS_MODE_ODD_SKIP,
      SPS_MODE_ODD_SKIP_NS
   } sps_mode_t;
   typedef enum logic [1:0] {
      SPS_ST_OFF,
      SPS_ST_SOFT,
      SPS_ST_RUN
   } sps_state_t;
endpackage

// ==== sps_sync.sv ====
// Two flip-flop synchroniser bank for comparator inputs
`timescale 1ns/1ps
module sps_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;
   // Next values of both stages
   always_comb begin
      meta_d = async_i;
      sync_d = meta_q;
   end
   // Register both stages
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end
   assign sync_o = sync_q;
endmodule

// ==== sps_ext_blank.sv ====
// Extended blanking counter driving the pin charge and discharge switches
`timescale 1ns/1ps
module sps_ext_blank #(
   parameter int COUNT = 256
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic start_i,
   input wire logic pin_low_i,
   input wire logic pin_high_i,
   output logic charge_switch_o,
   output logic discharge_switch_o,
   output logic done_o
);
   localparam int CW = $clog2(COUNT + 1);
   typedef enum logic [1:0] {SPS_EB_IDLE, SPS_EB_DIS, SPS_EB_CHG, SPS_EB_DONE} sps_eb_t;
   sps_eb_t st_q, st_d;
   logic [CW-1:0] cnt_q, cnt_d;
   // Next state of the swing counter
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      case (st_q)
         SPS_EB_IDLE: begin
            cnt_d = '0;
            if (start_i) st_d = SPS_EB_DIS;
         end
         SPS_EB_DIS: begin
            if (!start_i) st_d = SPS_EB_IDLE;
            else if (pin_low_i) st_d = SPS_EB_CHG; // see [RL7]
         end
         SPS_EB_CHG: begin
            if (!start_i) st_d = SPS_EB_IDLE;
            else if (pin_high_i) begin // see [RL7]
               cnt_d = cnt_q + 1'b1;
               st_d = (cnt_q == CW'(COUNT - 1)) ? SPS_EB_DONE : SPS_EB_DIS; // see [RL8]
            end
         end
         default: begin
            if (!start_i) st_d = SPS_EB_IDLE;
         end
      endcase
   end
   // Register the counter and switch outputs
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         st_q <= SPS_EB_IDLE;
         cnt_q <= '0;
         charge_switch_o <= 1'b0;
         discharge_switch_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         charge_switch_o <= (st_d == SPS_EB_CHG);
         discharge_switch_o <= (st_d == SPS_EB_DIS);
         done_o <= (st_d == SPS_EB_DONE); // see [RL8]
      end
   end
endmodule

// ==== sps_top.sv ====
// Top of the supply protection sequencer
`timescale 1ns/1ps
module sps_top #(
   parameter int BLANK_CYCLES = sps_pkg::BLANK_CYC,
   parameter int SPIKE_CYCLES = sps_pkg::SPIKE_CYC,
   parameter int EXT_COUNT = sps_pkg::EXT_COUNT
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic rail_above_7v_i,
   input wire logic rail_below_10v5_i,
   input wire logic rail_above_17v_i,
   input wire logic rail_above_20v5_i,
   input wire logic rail_above_25v5_i,
   input wire logic feedback_node_above_4v5_i,
   input wire logic temp_trip_i,
   input wire logic temp_release_i,
   input wire logic blanking_brownout_pin_above_0v9_i,
   input wire logic blanking_brownout_pin_above_4v5_i,
   output logic running_o,
   output logic switching_en_o,
   output logic soft_start_o,
   output logic startup_charge_en_o,
   output logic charge_switch_o,
   output logic discharge_switch_o,
   output logic load_switch_o,
   output logic brownout_latch_o,
   output logic ext_done_o,
   output sps_pkg::sps_mode_t mode_o,
   output logic odd_cycle_o
);
   import sps_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisation
   logic [SYNC_W-1:0] raw, syn;
   logic r7, r10, r17, r20, r25, fb45, t_trip, t_rel, pin09, pin45;
   assign raw = {rail_above_7v_i, rail_below_10v5_i, rail_above_17v_i, rail_above_20v5_i,
                 rail_above_25v5_i, feedback_node_above_4v5_i, temp_trip_i, temp_release_i,
                 blanking_brownout_pin_above_0v9_i, blanking_brownout_pin_above_4v5_i};
   // Every comparator passes two flops, see [RL18]
   sps_sync #(.W(SYNC_W)) u_sync (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .async_i(raw),
      .sync_o(syn)
   );
   assign {r7, r10, r17, r20, r25, fb45, t_trip, t_rel, pin09, pin45} = syn;

   ////////////////////////////////////////////////////////////////////////
   // State
   sps_state_t st_q, st_d;
   sps_mode_t mode_q, mode_d;
   logic odd_q, odd_d;
   logic ot_q, ot_d;
   logic bo_q, bo_d;
   logic [31:0] blank_q, blank_d;
   logic [31:0] spike_q, spike_d;
   logic [31:0] soft_q, soft_d;
   logic ext_start_q, ext_start_d;
   logic ext_done;
   logic chg_sw, dis_sw;
   logic fault;
   logic detect;

   // Extended blanking counter, started by the built-in timer, see [RL6]
   sps_ext_blank #(.COUNT(EXT_COUNT)) u_ext (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .start_i(ext_start_q),
      .pin_low_i(!pin09),
      .pin_high_i(pin45),
      .charge_switch_o(chg_sw),
      .discharge_switch_o(dis_sw),
      .done_o(ext_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // Protection next-state logic
   always_comb begin
      st_d = st_q;
      mode_d = mode_q;
      odd_d = odd_q;
      ot_d = ot_q;
      bo_d = bo_q;
      blank_d = blank_q;
      spike_d = spike_q;
      soft_d = soft_q;
      ext_start_d = ext_start_q;
      fault = 1'b0;
      // Detection is off in odd skip cycles, see [RL16]
      detect = !(mode_q != SPS_MODE_NORMAL && odd_q);
      // Temperature with hysteresis, see [RL3] [RL4]
      if (t_trip) ot_d = 1'b1;
      else if (t_rel) ot_d = 1'b0;
      // Brownout latch follows the pin comparator once the rail is above 7 V, holds below, see [RL11] [RL12]
      if (r7 && pin09) bo_d = 1'b0; // see [RL14]
      else if (r7) bo_d = 1'b1; // see [RL15]
      // Built-in blanking timer, see [RL6] [RL10]
      if (st_q != SPS_ST_OFF && fb45 && detect) begin
         if (blank_q < 32'(BLANK_CYCLES)) blank_d = blank_q + 32'd1;
      end else begin
         blank_d = '0;
      end
      ext_start_d = (blank_d >= 32'(BLANK_CYCLES)); // see [RL6]
      // Spike filter on done and overload, see [RL9]
      if (ext_done && fb45) begin
         if (spike_q < 32'(SPIKE_CYCLES)) spike_d = spike_q + 32'd1;
      end else begin
         spike_d = '0;
      end
      case (st_q)
         SPS_ST_OFF: begin
            blank_d = '0;
            // Top rail level and temperature faults are taken while off as well
            if (ot_q) mode_d = SPS_MODE_ODD_SKIP_NS; // see [RL3]
            else if (r25) mode_d = SPS_MODE_ODD_SKIP; // see [RL2]
            if (r17 && !r10) begin // see [RL5]
               odd_d = !odd_q;
               if (mode_q != SPS_MODE_NORMAL && odd_q) begin
                  st_d = SPS_ST_SOFT; // even cycle follows: detect
               end else if (mode_q != SPS_MODE_NORMAL) begin
                  st_d = SPS_ST_OFF; // odd cycle skipped, see [RL16]
               end else begin
                  st_d = SPS_ST_SOFT;
               end
               soft_d = '0;
            end
         end
         SPS_ST_SOFT, SPS_ST_RUN: begin
            if (st_q == SPS_ST_SOFT) begin
               soft_d = soft_q + 32'd1;
               if (soft_q >= 32'(BLANK_CYCLES)) st_d = SPS_ST_RUN;
            end
            if (r25) fault = 1'b1; // see [RL2]
            if (st_q == SPS_ST_SOFT && r20 && fb45) fault = 1'b1; // see [RL1]
            if (spike_q >= 32'(SPIKE_CYCLES)) fault = 1'b1; // see [RL9]
            if (ot_q) begin
               mode_d = SPS_MODE_ODD_SKIP_NS; // see [RL3]
               st_d = SPS_ST_OFF;
            end else if (fault) begin
               mode_d = SPS_MODE_ODD_SKIP;
               st_d = SPS_ST_OFF;
            end else if (mode_q != SPS_MODE_NORMAL && st_q == SPS_ST_RUN) begin
               mode_d = SPS_MODE_NORMAL; // release only in even cycle, see [RL16] [RL17]
            end
            if (r10) st_d = SPS_ST_OFF; // see [RL5]
            if (st_d == SPS_ST_OFF) odd_d = 1'b0;
         end
         default: st_d = SPS_ST_OFF;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Register all state and the outputs not driven by the extended counter
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         st_q <= SPS_ST_OFF;
         mode_q <= SPS_MODE_NORMAL;
         odd_q <= 1'b0;
         ot_q <= 1'b0;
         bo_q <= 1'b1; // see [RL12]
         blank_q <= '0;
         spike_q <= '0;
         soft_q <= '0;
         ext_start_q <= 1'b0;
         running_o <= 1'b0;
         switching_en_o <= 1'b0;
         soft_start_o <= 1'b0;
         startup_charge_en_o <= 1'b1;
         load_switch_o <= 1'b1;
         brownout_latch_o <= 1'b1;
         mode_o <= SPS_MODE_NORMAL;
         odd_cycle_o <= 1'b0;
      end else begin
         st_q <= st_d;
         mode_q <= mode_d;
         odd_q <= odd_d;
         ot_q <= ot_d;
         bo_q <= bo_d;
         blank_q <= blank_d;
         spike_q <= spike_d;
         soft_q <= soft_d;
         ext_start_q <= ext_start_d;
         running_o <= (st_d != SPS_ST_OFF);
         // No pulses in brownout or non-switching mode, see [RL13] [RL17]
         switching_en_o <= (st_d != SPS_ST_OFF) && !bo_d && (mode_d != SPS_MODE_ODD_SKIP_NS);
         soft_start_o <= (st_d == SPS_ST_SOFT);
         startup_charge_en_o <= (st_d == SPS_ST_OFF); // see [RL5]
         load_switch_o <= bo_d; // see [RL14] [RL15]
         brownout_latch_o <= bo_d;
         mode_o <= mode_d;
         odd_cycle_o <= odd_d;
      end
   end
   assign charge_switch_o = chg_sw;
   assign discharge_switch_o = dis_sw;
   assign ext_done_o = ext_done;
endmodule

// ==== sps_monitor.sv ====
// Checker of the sequencer outputs against fault and blanking behaviour
`timescale 1ns/1ps
module sps_monitor (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic rail_below_10v5_i,
   input wire logic rail_above_25v5_i,
   input wire logic temp_trip_i,
   input wire logic running_o,
   input wire logic switching_en_o,
   input wire logic charge_switch_o,
   input wire logic discharge_switch_o,
   input wire logic brownout_latch_o,
   input wire logic ext_done_o,
   input wire sps_pkg::sps_mode_t mode_o,
   input wire logic odd_cycle_o
);
   import sps_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   ////////////////////////////////////////////////////////////////
   // Pin switches never short the blanking pin and stay off after done
   property p_excl; !(charge_switch_o && discharge_switch_o); endproperty
   a_excl: assert property (p_excl) else $error("both pin switches on");
   property p_done; ext_done_o |-> !charge_switch_o && !discharge_switch_o; endproperty
   a_done: assert property (p_done) else $error("pin switched after done");
   // Switching suppression
   property p_bo; brownout_latch_o |-> !switching_en_o; endproperty
   a_bo: assert property (p_bo) else $error("switching in brownout");
   property p_ns; mode_o == SPS_MODE_ODD_SKIP_NS |-> !switching_en_o; endproperty
   a_ns: assert property (p_ns) else $error("switching in non-switching mode");
   property p_odd; odd_cycle_o && mode_o != SPS_MODE_NORMAL |-> !switching_en_o; endproperty
   a_odd: assert property (p_odd) else $error("switching in odd cycle");
   // Fault entry
   property p_ovp; rail_above_25v5_i [*4] |-> ##[0:3] mode_o != SPS_MODE_NORMAL; endproperty
   a_ovp: assert property (p_ovp) else $error("rail over level ignored");
   property p_otp; temp_trip_i [*4] |-> ##[0:3] mode_o != SPS_MODE_NORMAL; endproperty
   a_otp: assert property (p_otp) else $error("over temperature ignored");
   property p_uv; rail_below_10v5_i [*4] |-> ##[0:3] !running_o; endproperty
   a_uv: assert property (p_uv) else $error("running below low rail");
endmodule
bind sps_top sps_monitor mon_u (.clk_i, .reset_i, .rail_below_10v5_i, .rail_above_25v5_i, .temp_trip_i,
   .running_o, .switching_en_o, .charge_switch_o, .discharge_switch_o, .brownout_latch_o, .ext_done_o,
   .mode_o, .odd_cycle_o);

// ==== sps_pin_model.sv ====
// Model of the blanking and brownout pin with its capacitor and divider
`timescale 1ns/1ps
module sps_pin_model (
   input wire logic clk_i,
   input wire logic charge_i,
   input wire logic discharge_i,
   input wire logic [5:0] bulk_i,
   input wire logic [3:0] step_i,
   output logic above_0v9_o,
   output logic above_4v5_o
);
   int lvl = 0;
   // Pin level in tenths of a volt, follows the divider when no switch is on
   always @(posedge clk_i) begin
      if (discharge_i) lvl <= (lvl > step_i) ? lvl - step_i : 0;
      else if (charge_i) lvl <= (lvl + step_i > 50) ? 50 : lvl + step_i;
      else lvl <= bulk_i;
   end
   assign above_0v9_o = lvl >= 9;
   assign above_4v5_o = lvl >= 45;
endmodule

// ==== sps_top_tb.sv ====
// Self-checking testbench of the supply protection sequencer
`timescale 1ns/1ps
module sps_top_tb;
   import sps_pkg::*;
   logic clk_i = 0, reset_i = 1, a7 = 0, b10 = 1, a17 = 0, a20 = 0, a25 = 0, fb = 0, tt = 0, tr = 0;
   logic p09, p45, run, sw, ss, sc, chg, dis, ld, lat, dn, odd;
   sps_mode_t mode;
   logic [5:0] bulk = 6'h14;
   logic [3:0] step = 4'h2;
   // Shortened counts so that each scenario stays short
   localparam int TB_BLANK = 50;
   localparam int TB_SPIKE = 5;
   localparam int TB_EXT = 4;
   int n_mismatch = 0, cmp_count = 0, cyc = 0, i;
   logic [31:0] seed = 32'h32;
   always #20 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////////
   // Design with shortened counts, and the pin partner
   sps_top #(.BLANK_CYCLES(TB_BLANK), .SPIKE_CYCLES(TB_SPIKE), .EXT_COUNT(TB_EXT)) dut_u (.clk_i(clk_i),
      .reset_i(reset_i),
      .rail_above_7v_i(a7), .rail_below_10v5_i(b10), .rail_above_17v_i(a17), .rail_above_20v5_i(a20),
      .rail_above_25v5_i(a25), .feedback_node_above_4v5_i(fb), .temp_trip_i(tt), .temp_release_i(tr),
      .blanking_brownout_pin_above_0v9_i(p09), .blanking_brownout_pin_above_4v5_i(p45),
      .running_o(run), .switching_en_o(sw), .soft_start_o(ss), .startup_charge_en_o(sc),
      .charge_switch_o(chg), .discharge_switch_o(dis), .load_switch_o(ld), .brownout_latch_o(lat),
      .ext_done_o(dn), .mode_o(mode), .odd_cycle_o(odd));
   sps_pin_model pin_u (.clk_i(clk_i), .charge_i(chg), .discharge_i(dis), .bulk_i(bulk), .step_i(step),
      .above_0v9_o(p09), .above_4v5_o(p45));
   ////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [1:0] pick(int s);
      case (s)
         0: return {1'b0, run};
         1: return {1'b0, ss};
         2: return {1'b0, lat};
         3: return {1'b0, dn};
         4: return {1'b0, dis};
         5: return {1'b0, sc};
         6: return {1'b0, ld};
         8: return {1'b0, sw};
         9: return {1'b0, chg};
         10: return {1'b0, odd};
         default: return mode;
      endcase
   endfunction
   // Mode that each scenario must reach after its stimulus
   function automatic logic [1:0] exp_mode(int t);
      case (t)
         0, 1, 3: return SPS_MODE_ODD_SKIP;
         2: return SPS_MODE_ODD_SKIP_NS;
         default: return SPS_MODE_NORMAL;
      endcase
   endfunction
   task automatic check(string nm, logic [1:0] seen, logic [1:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s exp %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic wait_for(int s, logic [1:0] v, string nm, int lim);
      int k;
      for (k = 0; k < lim && pick(s) !== v; k++) begin
         @(posedge clk_i);
         #1;
      end
      check(nm, pick(s), v);
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Cut a hang short
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         final_report();
      end
   end
   ////////////////////////////////////////////////////////////////
   // Seven scenarios, one per fault kind plus a rail and feedback high check after soft start, each from a fresh reset
   initial begin
      for (i = 0; i < 7; i++) begin
         @(posedge clk_i);
         {reset_i, b10, a7, a17, a20, a25, fb, tt, tr} <= 9'h180;
         bulk <= 6'h14;
         step <= 4'(2 + xs() % 8);
         repeat (2) @(posedge clk_i);
         #1;
         check("latch", pick(2), 2'h1);
         check("load", pick(6), 2'h1);
         check("start", pick(5), 2'h1);
         @(posedge clk_i);
         reset_i <= 0;
         a7 <= 1;
         b10 <= 0;
         a17 <= 1;
         wait_for(2, 2'h0, "latch", 40);
         check("load", pick(6), 2'h0);
         wait_for(0, 2'h1, "run", 40);
         check("soft", pick(1), 2'h1);
         check("sw", pick(8), 2'h1);
         if (i > 0) wait_for(1, 2'h0, "soft", 100);
         repeat (xs() % 8 + 1) @(posedge clk_i);
         case (i)
            0, 5: {a20, fb} <= 2'h3;
            1: a25 <= 1;
            2: tt <= 1;
            3: fb <= 1;
            4: {b10, a17} <= 2'h2;
            default: bulk <= 6'h3;
         endcase
         if (i == 3) begin
            repeat (TB_BLANK - 10) @(posedge clk_i);
            #1;
            check("disch", pick(4), 2'h0);
            wait_for(4, 2'h1, "disch", 30);
            wait_for(9, 2'h1, "chg", 200);
            wait_for(3, 2'h1, "done", 600);
            repeat (TB_SPIKE - 1) @(posedge clk_i);
            #1;
            check("mode", pick(7), SPS_MODE_NORMAL);
         end
         if (i == 4) begin
            wait_for(0, 2'h0, "run", 20);
            check("start", pick(5), 2'h1);
         end
         if (i == 6) begin
            wait_for(2, 2'h1, "latch", 20);
            check("load", pick(6), 2'h1);
            check("sw", pick(8), 2'h0);
            @(posedge clk_i);
            bulk <= 6'h14;
            wait_for(2, 2'h0, "latch", 20);
            check("sw", pick(8), 2'h1);
         end
         if (i == 5) begin
            repeat (20) @(posedge clk_i);
            #1;
         end
         wait_for(7, exp_mode(i), "mode", 60);
         // Odd cycle stays off, even cycle turns on with or without pulses
         if (i == 1 || i == 2) begin
            wait_for(10, 2'h1, "odd", 4);
            check("run", pick(0), 2'h0);
            wait_for(0, 2'h1, "run", 4);
            check("sw", pick(8), {1'b0, i == 1});
         end
         // Trip cleared but not yet released, then released
         if (i == 2) begin
            @(posedge clk_i);
            tt <= 0;
            repeat (TB_BLANK * 2) @(posedge clk_i);
            #1;
            check("mode", pick(7), SPS_MODE_ODD_SKIP_NS);
            @(posedge clk_i);
            tr <= 1;
            wait_for(7, SPS_MODE_NORMAL, "mode", TB_BLANK * 3);
         end
         $display("test %0d done", i);
      end
      final_report();
   end
endmodule
